// >>> hdl/acfg_consts.svh
`ifndef ACFG_CONSTS_SVH
`define ACFG_CONSTS_SVH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define ACFG_ADDR_CH_INDEX      13'h0005
`define ACFG_ADDR_CLK_DIV       13'h000B
`define ACFG_ADDR_OUT_MODE      13'h0014
`define ACFG_ADDR_OUT_ADJUST    13'h0015
`define ACFG_ADDR_OUT_PHASE     13'h0016
`define ACFG_ADDR_SER_CTRL      13'h0021
`define ACFG_ADDR_TRANSFER      13'h00FF
`define ACFG_ADDR_OVERRIDE      13'h0100
`define ACFG_ADDR_PULLDOWN      13'h0101
`define ACFG_ADDR_CM_CTRL       13'h0102

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define ACFG_RST_CH_INDEX       8'h3F
`define ACFG_RST_OUT_MODE       8'h01
`define ACFG_RST_OUT_PHASE      8'h03
`define ACFG_RST_SER_CTRL       8'h30

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define ACFG_FMT_BIT            0
`define ACFG_TERM_MSB           5
`define ACFG_TERM_LSB           4
`define ACFG_DRIVE_BIT          0
`define ACFG_IN_PH_MSB          6
`define ACFG_IN_PH_LSB          4
`define ACFG_OUT_PH_MSB         3
`define ACFG_OUT_PH_LSB         0
`define ACFG_DIV_MSB            2
`define ACFG_DIV_LSB            0
`define ACFG_XFER_BIT           0
`define ACFG_OVR_EN_BIT         6
`define ACFG_OVR_RES_MSB        5
`define ACFG_OVR_RES_LSB        4
`define ACFG_OVR_RATE_MSB       2
`define ACFG_OVR_RATE_LSB       0
`define ACFG_PD_DIS_BIT         0
`define ACFG_CM_PD_BIT          3
`define ACFG_CLKGRP_LSB         4
`define ACFG_PHASE_STEP_DEG     10'h03C

// ----------------------------------------------------------------
// Serial port frame layout
// ----------------------------------------------------------------
`define ACFG_INSTR_BITS         5'h10
`define ACFG_FRAME_BITS         5'h18

`endif

// >>> hdl/acfg_pkg.sv
package acfg_pkg;

    typedef logic [12:0] acfg_addr_t;
    typedef logic [7:0]  acfg_byte_t;

    typedef enum logic [2:0] {
        ACFG_LANE_SDR_BIT,
        ACFG_LANE_SDR_BYTE,
        ACFG_LANE_DDR_BIT,
        ACFG_LANE_DDR_BYTE,
        ACFG_LANE_DDR_WORD
    } acfg_lane_t;

endpackage

// >>> hdl/acfg_spi_port.sv
`timescale 1ns/1ns
`include "acfg_consts.svh"

module acfg_spi_port (
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    input  wire logic             sclk_pin,
    input  wire logic             csb_n_pin,
    input  wire logic             sdio_in,
    output logic                  sdio_out,
    output logic                  sdio_oe,
    output acfg_pkg::acfg_addr_t  reg_addr,
    output logic                  wr_stb,
    output acfg_pkg::acfg_byte_t  wr_data,
    output logic                  rd_stb,
    input  wire acfg_pkg::acfg_byte_t rd_data
);

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    logic [1:0] sclk_s;
    logic [1:0] csb_s;
    logic [1:0] sdio_s;
    logic       sclk_d;
    logic [4:0] bit_cnt;
    logic [15:0] shift_in;
    logic       is_read;
    logic       rd_pend;
    acfg_pkg::acfg_byte_t shift_out;
    logic       sclk_rise;
    logic       sclk_fall;
    logic       active;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            sclk_s <= 2'h0;
            csb_s  <= 2'h3;
            sdio_s <= 2'h0;
            sclk_d <= 1'b0;
        end else begin
            sclk_s <= {sclk_s[0], sclk_pin};
            csb_s  <= {csb_s[0], csb_n_pin};
            sdio_s <= {sdio_s[0], sdio_in};
            sclk_d <= sclk_s[1];
        end
    end

    assign sclk_rise = sclk_s[1] & ~sclk_d;
    assign sclk_fall = ~sclk_s[1] & sclk_d;
    assign active    = ~csb_s[1];

    // ------------------------------------------------------------
    // Instruction and write data capture
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            bit_cnt  <= 5'h0;
            shift_in <= 16'h0000;
            is_read  <= 1'b0;
            reg_addr <= 13'h0000;
            wr_data  <= 8'h00;
        end else if (!active) begin
            bit_cnt <= 5'h0;
            is_read <= 1'b0;
        end else if (sclk_rise) begin
            shift_in <= {shift_in[14:0], sdio_s[1]};
            if (bit_cnt != `ACFG_FRAME_BITS) begin
                bit_cnt <= bit_cnt + 5'h1;
            end
            if (bit_cnt == `ACFG_INSTR_BITS - 5'h1) begin
                is_read  <= shift_in[14];
                reg_addr <= {shift_in[11:0], sdio_s[1]};
            end
            if (bit_cnt == `ACFG_FRAME_BITS - 5'h1) begin
                wr_data <= {shift_in[6:0], sdio_s[1]};
            end
        end
    end

    // ------------------------------------------------------------
    // Strobes to the register bank
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            wr_stb  <= 1'b0;
            rd_pend <= 1'b0;
            rd_stb  <= 1'b0;
        end else begin
            wr_stb  <= active & sclk_rise & ~is_read
                     & (bit_cnt == `ACFG_FRAME_BITS - 5'h1);
            rd_pend <= active & sclk_rise & shift_in[14]
                     & (bit_cnt == `ACFG_INSTR_BITS - 5'h1);
            rd_stb  <= rd_pend & active;
        end
    end

    // ------------------------------------------------------------
    // Read data, launched on falling clock edges
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            shift_out <= 8'h00;
        end else if (rd_stb) begin
            shift_out <= rd_data;
        end else if (sclk_fall && bit_cnt > `ACFG_INSTR_BITS) begin
            shift_out <= {shift_out[6:0], 1'b0};
        end
    end

    assign sdio_out = shift_out[7];
    assign sdio_oe  = active & is_read & (bit_cnt >= `ACFG_INSTR_BITS)
                    & (bit_cnt < `ACFG_FRAME_BITS);

endmodule

// >>> hdl/acfg_mode_decode.sv
`timescale 1ns/1ns

module acfg_mode_decode (
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    input  wire acfg_pkg::acfg_byte_t code,
    output logic                  mode_valid,
    output logic                  word_12bit,
    output logic                  frame_double,
    output acfg_pkg::acfg_lane_t  lane_mode,
    output logic [3:0]            dck_multiplier
);

    logic                 ok;
    acfg_pkg::acfg_lane_t lane;
    logic [3:0]           mult;

    // ------------------------------------------------------------
    // Code decode
    // ------------------------------------------------------------
    always_comb begin
        lane = acfg_pkg::acfg_lane_t'(code[6:4]);
        ok   = ~code[7] & ~code[3] & ~code[0] & (code[6:4] <= 3'h4)
             & ~(code[6] & code[2]);
        unique case (lane)
            acfg_pkg::ACFG_LANE_DDR_BIT,
            acfg_pkg::ACFG_LANE_DDR_BYTE:
                mult = code[1] ? 4'h3 : 4'h4;
            default:
                mult = code[1] ? 4'h6 : 4'h8;
        endcase
    end

    // ------------------------------------------------------------
    // Registered mode; unlisted codes fall back to the reset mode
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            mode_valid     <= 1'b1;
            word_12bit     <= 1'b0;
            frame_double   <= 1'b0;
            lane_mode      <= acfg_pkg::ACFG_LANE_DDR_BYTE;
            dck_multiplier <= 4'h4;
        end else begin
            mode_valid     <= ok;
            word_12bit     <= ok & code[1];
            frame_double   <= ok & code[2];
            lane_mode      <= ok ? lane : acfg_pkg::ACFG_LANE_DDR_BYTE;
            dck_multiplier <= ok ? mult : 4'h4;
        end
    end

endmodule

// >>> hdl/acfg_regs.sv
`timescale 1ns/1ns
`include "acfg_consts.svh"

// Overview of operation
// - Format bit: one twos complement, zero offset binary.
// - Output adjust bits 5:4 pick driver termination.
// - Output adjust bit 0: clock-output drive single or double.
// - Selected termination overrides double clock drive.
// - Input phase delays sampling 0-7 cycles when divider is used.
// - Output phase shifts data clock in 60 degree steps, default 180.
// - Override settings apply only on transfer bit 0.
// - Override limits capability and resolution only.
// - Pull-down control bit 0 disconnects the pin pull-down.
// - Common-mode control bit 3 powers down the generator.
// - Serialization code resets to 0x30: 16-bit DDR bytewise, clock 4x.
// - Codes 0x20, 0x10, 0x00 give other 16-bit single-frame lane modes.
// - Codes 0x34, 0x24, 0x14, 0x04 are double-frame 16-bit variants.
// - 12-bit codes give single and double frame modes at 3x or 6x.
// - Codes 0x40 and 0x42 give one-lane wordwise at 8x or 6x.
// - Channel index picks channels for per-channel writes.
module acfg_regs #(
    parameter int NUM_CH      = 4,
    parameter int NUM_CLK_GRP = 2
) (
    input  wire logic             clk_sys,
    input  wire logic             arst_n,
    input  wire logic             sclk_pin,
    input  wire logic             csb_n_pin,
    input  wire logic             sdio_in,
    output logic                  sdio_out,
    output logic                  sdio_oe,
    output logic                  twos_complement,
    output logic [2*NUM_CH-1:0]   data_termination,
    output logic [2*NUM_CLK_GRP-1:0] clock_termination,
    output logic [NUM_CLK_GRP-1:0] clock_drive_double,
    output logic [2:0]            sample_delay_cycles,
    output logic [3:0]            dck_phase_code,
    output logic [9:0]            dck_phase_degrees,
    output logic                  mode_valid,
    output logic                  word_12bit,
    output logic                  frame_double,
    output acfg_pkg::acfg_lane_t  lane_mode,
    output logic [3:0]            dck_multiplier,
    output logic                  override_enable,
    output logic [1:0]            override_resolution,
    output logic [2:0]            override_rate,
    output logic                  level_pin_pulldown_off,
    output logic                  common_mode_generator_off
);

    // ------------------------------------------------------------
    // Parameter check
    // ------------------------------------------------------------
    if (!(NUM_CH inside {[1:4]}) || !(NUM_CLK_GRP inside {[1:2]})) begin
        $error("unsupported channel or clock group count");
    end

    // ------------------------------------------------------------
    // Serial port
    // ------------------------------------------------------------
    acfg_pkg::acfg_addr_t reg_addr;
    acfg_pkg::acfg_byte_t wr_data;
    acfg_pkg::acfg_byte_t rd_data;
    logic                 wr_stb;
    logic                 rd_stb;

    acfg_spi_port u_port (
        .clk_sys   (clk_sys),
        .arst_n    (arst_n),
        .sclk_pin  (sclk_pin),
        .csb_n_pin (csb_n_pin),
        .sdio_in   (sdio_in),
        .sdio_out  (sdio_out),
        .sdio_oe   (sdio_oe),
        .reg_addr  (reg_addr),
        .wr_stb    (wr_stb),
        .wr_data   (wr_data),
        .rd_stb    (rd_stb),
        .rd_data   (rd_data)
    );

    function automatic logic hit(input acfg_pkg::acfg_addr_t a);
        return wr_stb && (reg_addr == a);
    endfunction

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    acfg_pkg::acfg_byte_t ch_index;
    logic [2:0]           clk_div_ratio;
    acfg_pkg::acfg_byte_t out_mode;
    acfg_pkg::acfg_byte_t out_phase;
    acfg_pkg::acfg_byte_t ser_ctrl;
    acfg_pkg::acfg_byte_t override_shadow;
    acfg_pkg::acfg_byte_t pulldown_ctrl;
    acfg_pkg::acfg_byte_t cm_ctrl;
    logic [1:0]           term_ch  [NUM_CH];
    logic [1:0]           term_clk [NUM_CLK_GRP];
    logic                 drive_clk[NUM_CLK_GRP];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ch_index      <= `ACFG_RST_CH_INDEX;
            clk_div_ratio <= 3'h0;
            out_mode      <= `ACFG_RST_OUT_MODE;
            out_phase     <= `ACFG_RST_OUT_PHASE;
            ser_ctrl      <= `ACFG_RST_SER_CTRL;
            pulldown_ctrl <= 8'h00;
            cm_ctrl       <= 8'h00;
        end else begin
            if (hit(`ACFG_ADDR_CH_INDEX))
                ch_index <= wr_data;
            if (hit(`ACFG_ADDR_CLK_DIV))
                clk_div_ratio <= wr_data[`ACFG_DIV_MSB:`ACFG_DIV_LSB];
            if (hit(`ACFG_ADDR_OUT_MODE))
                out_mode <= wr_data;
            if (hit(`ACFG_ADDR_OUT_PHASE))
                out_phase <= {1'b0, wr_data[6:0]};
            if (hit(`ACFG_ADDR_SER_CTRL))
                ser_ctrl <= wr_data;
            if (hit(`ACFG_ADDR_PULLDOWN))
                pulldown_ctrl <= {7'h00, wr_data[`ACFG_PD_DIS_BIT]};
            if (hit(`ACFG_ADDR_CM_CTRL))
                cm_ctrl <= {4'h0, wr_data[`ACFG_CM_PD_BIT], 3'h0};
        end
    end

    // ------------------------------------------------------------
    // Per-channel output adjust, steered by the channel index
    // ------------------------------------------------------------
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                term_ch[i] <= 2'h0;
            end else if (hit(`ACFG_ADDR_OUT_ADJUST) && ch_index[i]) begin
                term_ch[i] <= wr_data[`ACFG_TERM_MSB:`ACFG_TERM_LSB];
            end
        end
        assign data_termination[2*i +: 2] = term_ch[i];
    end

    for (genvar g = 0; g < NUM_CLK_GRP; g++) begin : g_clk
        logic sel;
        assign sel = ch_index[`ACFG_CLKGRP_LSB + g];
        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                term_clk[g]  <= 2'h0;
                drive_clk[g] <= 1'b0;
            end else if (hit(`ACFG_ADDR_OUT_ADJUST) && sel) begin
                term_clk[g]  <= wr_data[`ACFG_TERM_MSB:`ACFG_TERM_LSB];
                drive_clk[g] <= wr_data[`ACFG_DRIVE_BIT];
            end
        end
        always_ff @(posedge clk_sys or negedge arst_n) begin
            if (!arst_n) begin
                clock_drive_double[g] <= 1'b0;
            end else begin
                // Termination takes precedence over double drive
                clock_drive_double[g] <= drive_clk[g]
                                       & (term_clk[g] == 2'h0);
            end
        end
        assign clock_termination[2*g +: 2] = term_clk[g];
    end

    // ------------------------------------------------------------
    // Override register with transfer strobe
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            override_shadow <= 8'h00;
        end else if (hit(`ACFG_ADDR_OVERRIDE)) begin
            override_shadow <= {1'b0, wr_data[6:4], 1'b0, wr_data[2:0]};
        end
    end

    // Capability limits only; the conversion clock is untouched
    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            override_enable     <= 1'b0;
            override_resolution <= 2'h0;
            override_rate       <= 3'h0;
        end else if (hit(`ACFG_ADDR_TRANSFER)
                     && wr_data[`ACFG_XFER_BIT]) begin
            override_enable     <= override_shadow[`ACFG_OVR_EN_BIT];
            override_resolution <=
                override_shadow[`ACFG_OVR_RES_MSB:`ACFG_OVR_RES_LSB];
            override_rate       <=
                override_shadow[`ACFG_OVR_RATE_MSB:`ACFG_OVR_RATE_LSB];
        end
    end

    // ------------------------------------------------------------
    // Derived outputs
    // ------------------------------------------------------------
    logic [2:0] in_phase;
    logic [3:0] out_ph;
    assign in_phase = out_phase[`ACFG_IN_PH_MSB:`ACFG_IN_PH_LSB];
    assign out_ph   = out_phase[`ACFG_OUT_PH_MSB:`ACFG_OUT_PH_LSB];

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            twos_complement           <= 1'b1;
            sample_delay_cycles       <= 3'h0;
            dck_phase_code            <= 4'h3;
            dck_phase_degrees         <= 10'h0B4;
            level_pin_pulldown_off    <= 1'b0;
            common_mode_generator_off <= 1'b0;
        end else begin
            twos_complement <= out_mode[`ACFG_FMT_BIT];
            // Phase only matters when the divider is in use
            sample_delay_cycles <= (clk_div_ratio != 3'h0)
                                 ? in_phase : 3'h0;
            dck_phase_code    <= out_ph;
            dck_phase_degrees <= 10'(out_ph * `ACFG_PHASE_STEP_DEG);
            level_pin_pulldown_off <= pulldown_ctrl[`ACFG_PD_DIS_BIT];
            common_mode_generator_off <= cm_ctrl[`ACFG_CM_PD_BIT];
        end
    end

    // ------------------------------------------------------------
    // Serialization mode decode
    // ------------------------------------------------------------
    acfg_mode_decode u_mode (
        .clk_sys        (clk_sys),
        .arst_n         (arst_n),
        .code           (ser_ctrl),
        .mode_valid     (mode_valid),
        .word_12bit     (word_12bit),
        .frame_double   (frame_double),
        .lane_mode      (lane_mode),
        .dck_multiplier (dck_multiplier)
    );

    // ------------------------------------------------------------
    // Read-back, from the lowest selected channel or clock group
    // ------------------------------------------------------------
    logic [1:0] rd_term;
    logic       rd_drive;

    always_comb begin
        rd_term  = 2'h0;
        rd_drive = 1'b0;
        for (int g = NUM_CLK_GRP - 1; g >= 0; g--) begin
            if (ch_index[`ACFG_CLKGRP_LSB + g]) begin
                rd_term  = term_clk[g];
                rd_drive = drive_clk[g];
            end
        end
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (ch_index[i]) begin
                rd_term = term_ch[i];
            end
        end
    end

    always_comb begin
        unique case (reg_addr)
            `ACFG_ADDR_CH_INDEX:   rd_data = ch_index;
            `ACFG_ADDR_CLK_DIV:    rd_data = {5'h00, clk_div_ratio};
            `ACFG_ADDR_OUT_MODE:   rd_data = out_mode;
            `ACFG_ADDR_OUT_ADJUST: rd_data = {2'h0, rd_term, 3'h0, rd_drive};
            `ACFG_ADDR_OUT_PHASE:  rd_data = out_phase;
            `ACFG_ADDR_SER_CTRL:   rd_data = ser_ctrl;
            `ACFG_ADDR_OVERRIDE:   rd_data = override_shadow;
            `ACFG_ADDR_PULLDOWN:   rd_data = pulldown_ctrl;
            `ACFG_ADDR_CM_CTRL:    rd_data = cm_ctrl;
            default:               rd_data = 8'h00;
        endcase
    end

endmodule

// >>> testbench/acfg_regs_checker.sv
`timescale 1ns/1ns

module acfg_regs_checker #(
    parameter int NUM_CH      = 4,
    parameter int NUM_CLK_GRP = 2
) (
    input wire logic                     clk_sys,
    input wire logic                     arst_n,
    input wire logic                     csb_n_pin,
    input wire logic                     twos_complement,
    input wire logic [2*NUM_CLK_GRP-1:0] clock_termination,
    input wire logic [NUM_CLK_GRP-1:0]   clock_drive_double,
    input wire logic [3:0]               dck_phase_code,
    input wire logic [9:0]               dck_phase_degrees,
    input wire logic                     mode_valid,
    input wire logic                     word_12bit,
    input wire logic                     frame_double,
    input wire acfg_pkg::acfg_lane_t     lane_mode,
    input wire logic [3:0]               dck_multiplier,
    input wire logic                     override_enable,
    input wire logic [2:0]               override_rate,
    input wire logic                     level_pin_pulldown_off,
    input wire logic                     common_mode_generator_off
);
    default clocking @(posedge clk_sys);
    endclocking
    default disable iff (!arst_n);
    logic ddr2;
    assign ddr2 = lane_mode == acfg_pkg::ACFG_LANE_DDR_BIT
               || lane_mode == acfg_pkg::ACFG_LANE_DDR_BYTE;

    a_reset_values: assert property (!$past(arst_n) |-> twos_complement
        && dck_phase_degrees == 10'h0B4 && dck_multiplier == 4'h4
        && lane_mode == acfg_pkg::ACFG_LANE_DDR_BYTE)
        else $error("outputs not at reset values");
    a_phase_degrees: assert property (
        dck_phase_degrees == 10'(dck_phase_code) * 10'h03C)
        else $error("phase degrees do not match code");
    a_term_over_drive: assert property (clock_termination[1:0] != 2'b00
        |=> !clock_drive_double[0]) else $error("double drive with termination");
    a_invalid_mode: assert property (!mode_valid |-> !word_12bit
        && !frame_double && dck_multiplier == 4'h4
        && lane_mode == acfg_pkg::ACFG_LANE_DDR_BYTE)
        else $error("unlisted code not shown as default mode");
    a_mult_table: assert property (mode_valid |-> dck_multiplier ==
        (word_12bit ? (ddr2 ? 4'h3 : 4'h6) : (ddr2 ? 4'h4 : 4'h8)))
        else $error("clock multiplier does not match lane mode");
    a_word_single: assert property (lane_mode ==
        acfg_pkg::ACFG_LANE_DDR_WORD |-> !frame_double)
        else $error("one-lane mode with double frame");
    a_rate_keeps_clock: assert property ($changed(override_rate)
        |-> $stable(dck_multiplier) && $stable(lane_mode))
        else $error("override changed the output clocking");
    a_hold_idle: assert property (csb_n_pin [*8] |=>
        $stable({twos_complement, override_enable, override_rate,
        level_pin_pulldown_off, common_mode_generator_off}))
        else $error("setting changed with the port idle");

    c_double_drive: cover property (clock_drive_double[0]);
    c_override: cover property (override_enable);
    c_bad_mode: cover property (!mode_valid);
endmodule

bind acfg_regs acfg_regs_checker #(
    .NUM_CH      (NUM_CH),
    .NUM_CLK_GRP (NUM_CLK_GRP)
) acfg_regs_checker_inst (.*);

// >>> testbench/acfg_host_model.sv
`timescale 1ns/1ns

module acfg_host_model (
    input  wire logic clk_sys,
    input  wire logic sdio_out,
    input  wire logic sdio_oe,
    output logic      sclk_pin,
    output logic      csb_n_pin,
    output logic      sdio_in
);
    logic host_bit;
    // Device owns the shared data line while it answers a read
    assign sdio_in = sdio_oe ? sdio_out : host_bit;
    initial begin
        sclk_pin = 1'b0;
        csb_n_pin = 1'b1;
        host_bit = 1'b0;
    end
    // Serial clock high lasts six clocks, low lasts seven
    task automatic xfer(input logic rd, input logic [12:0] a,
                        input logic [7:0] wd, output logic [7:0] rdat);
        logic [23:0] f;
        f = {rd, 2'b00, a, wd};
        rdat = 8'h00;
        @(posedge clk_sys) csb_n_pin <= 1'b0;
        for (int i = 23; i >= 0; i--) begin
            @(posedge clk_sys) host_bit <= (rd && i < 8) ? 1'b0 : f[i];
            repeat (5) @(posedge clk_sys);
            @(posedge clk_sys) sclk_pin <= 1'b1;
            if (i < 8) rdat[i] = sdio_in;
            repeat (5) @(posedge clk_sys);
            @(posedge clk_sys) sclk_pin <= 1'b0;
        end
        repeat (6) @(posedge clk_sys);
        @(posedge clk_sys) csb_n_pin <= 1'b1;
        host_bit <= ~host_bit;
        repeat (6) @(posedge clk_sys);
    endtask
endmodule

// >>> testbench/acfg_regs_tb.sv
`timescale 1ns/1ns
`include "acfg_consts.svh"

module acfg_regs_tb;
    logic clk_sys, arst_n, sclk_pin, csb_n_pin, sdio_in, sdio_out, sdio_oe;
    logic twos_complement, mode_valid, word_12bit, frame_double;
    logic override_enable, level_pin_pulldown_off, common_mode_generator_off;
    logic [7:0]           data_termination, rb;
    logic [3:0]           clock_termination, dck_phase_code, dck_multiplier;
    logic [1:0]           clock_drive_double, override_resolution;
    logic [2:0]           sample_delay_cycles, override_rate;
    logic [9:0]           dck_phase_degrees;
    acfg_pkg::acfg_lane_t lane_mode;
    int                   err_total = 0;
    int                   num_checks = 0;

    acfg_regs acfg_regs_inst (.*);
    acfg_host_model acfg_host_model_inst (.*);

    task automatic chk(input logic [15:0] got, exp, input string m);
        num_checks++;
        if (got !== exp) begin
            $display("CHECK FAILED %0t %s", $time, m);
            err_total++;
        end
    endtask
    task automatic wr(input logic [12:0] a, input logic [7:0] d);
        acfg_host_model_inst.xfer(1'b0, a, d, rb);
    endtask
    task automatic rd(input logic [12:0] a);
        acfg_host_model_inst.xfer(1'b1, a, 8'h00, rb);
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic t_reset();
        chk(dck_phase_degrees, 16'h00B4, "reset phase");
        chk({mode_valid, word_12bit, frame_double, lane_mode, dck_multiplier},
            16'h0234, "reset mode");
        rd(`ACFG_ADDR_SER_CTRL);
        chk(rb, 16'h0030, "control read");
    endtask
    task automatic t_format();
        wr(`ACFG_ADDR_OUT_MODE, 8'h00);
        chk(twos_complement, 16'h0000, "offset binary");
        wr(`ACFG_ADDR_OUT_MODE, 8'h01);
        chk(twos_complement, 16'h0001, "twos complement");
    endtask
    task automatic t_drive();
        wr(`ACFG_ADDR_CH_INDEX, 8'h31);
        wr(`ACFG_ADDR_OUT_ADJUST, 8'h01);
        chk(clock_drive_double, 16'h0003, "double drive");
        wr(`ACFG_ADDR_OUT_ADJUST, 8'h21);
        chk({clock_termination, clock_drive_double}, 16'h0028, "term");
        chk(data_termination, 16'h0002, "data term");
    endtask
    task automatic t_phase();
        wr(`ACFG_ADDR_CLK_DIV, 8'h07);
        wr(`ACFG_ADDR_OUT_PHASE, 8'h7B);
        chk({sample_delay_cycles, dck_phase_code}, 16'h007B, "phase");
        chk(dck_phase_degrees, 16'h0294, "phase degrees");
    endtask
    task automatic t_modes();
        logic [7:0] c;
        logic       d2;
        for (int i = 0; i < 18; i++) begin
            c = (i < 16) ? {2'b00, i[3:2], 1'b0, i[1:0], 1'b0}
                         : {2'b01, 4'h0, i[0], 1'b0};
            d2 = !c[6] && c[5];
            wr(`ACFG_ADDR_SER_CTRL, c);
            chk({mode_valid, word_12bit, frame_double}, {1'b1, c[1], c[2]},
                "word and frame");
            chk(lane_mode, c[6] ? 16'h0004 : {14'h0000, c[5:4]}, "lane");
            chk(dck_multiplier, c[1] ? (d2 ? 16'h0003 : 16'h0006)
                : (d2 ? 16'h0004 : 16'h0008), "multiplier");
        end
        wr(`ACFG_ADDR_SER_CTRL, 8'h31);
        chk({mode_valid, lane_mode, dck_multiplier}, 16'h0034, "unlisted");
    endtask
    task automatic t_override();
        wr(`ACFG_ADDR_OVERRIDE, 8'h65);
        chk({override_enable, override_resolution, override_rate}, 16'h0000,
            "no transfer");
        wr(`ACFG_ADDR_TRANSFER, 8'h01);
        chk({override_enable, override_resolution, override_rate}, 16'h0035,
            "transfer");
        chk(dck_multiplier, 16'h0004, "clocking kept");
    endtask
    task automatic t_io();
        wr(`ACFG_ADDR_PULLDOWN, 8'h01);
        chk(level_pin_pulldown_off, 16'h0001, "pull-down off");
        wr(`ACFG_ADDR_CM_CTRL, 8'h08);
        chk(common_mode_generator_off, 16'h0001, "generator off");
        wr(13'h1ABC, 8'hFF);
        rd(13'h1ABC);
        chk(rb, 16'h0000, "unmapped read");
    endtask

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end
    initial begin
        arst_n = 1'b0;
        repeat (16) @(posedge clk_sys);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk_sys);
        t_reset();
        t_format();
        t_drive();
        t_phase();
        t_modes();
        t_override();
        t_io();
        wrap_up();
    end
    initial begin
        #200_000;
        err_total++;
        wrap_up();
    end
endmodule
